//--- bench/ihp_core_model.sv
// register core stand-in: answers each read request one cycle later while slow is low
// assumes: rdReq is a one-cycle pulse, rdIndex held during the read
module ihp_core_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic       rdReq,
  input  wire logic [2:0] rdIndex,
  output logic            rdAck,
  output logic [15:0]     rdData
);
  timeunit 1ns;
  timeprecision 1ps;
  // data toggles between answers; slow withholds the answer entirely
  always @(posedge clk) begin
    rdAck <= 1'b0;
    rdData <= rst ? 16'h0f0f : ~rdData;
    if (rdReq && !slow && !rst) begin
      rdAck <= 1'b1;
      rdData <= {5'h00, rdIndex, 5'h00, rdIndex};
    end
  end
endmodule

//--- bench/ihp_sva.sv
// checker for the host port: decode, ready stretching, lane enables
// assumes: bound to ihp_host_port, one clock, sync active-high reset
module ihp_sva
  import ihp_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst,
  input wire ihp_pkg::ihp_bus_in_t busIn,
  input wire logic [15:0]          dataOe,
  input wire logic                 asyncReadyOut,
  input wire logic                 localDecodeHitN,
  input wire ihp_pkg::ihp_wr_t     wrReq,
  input wire logic                 rdReq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // decode follows upper address and qualifier
  dec_hit_a: assert property (localDecodeHitN == !(busIn.addr[15:4] ==
    BASE_DECODE && !busIn.ioQualifierN)) else $error("decode wrong");
  qual_ignore_a: assert property (busIn.ioQualifierN &&
    $past(busIn.ioQualifierN) |-> !rdReq && !wrReq.valid)
    else $error("access while qualifier high");
  rd_stall_a: assert property ($fell(busIn.readStrobeN) &&
    !localDecodeHitN |-> !asyncReadyOut) else $error("ready not dropped");
  rdy_return_a: assert property (!asyncReadyOut |->
    ##[1:6] asyncReadyOut) else $error("ready stuck low");
  wr_ready_a: assert property (!busIn.writeStrobeN |->
    asyncReadyOut) else $error("ready dropped on write");
  rd_request_a: assert property ($fell(busIn.readStrobeN) &&
    !localDecodeHitN |=> rdReq) else $error("no read request");
  wr_take_a: assert property ($rose(busIn.writeStrobeN) &&
    !$past(localDecodeHitN) |=> wrReq.valid) else $error("write lost");
  upper_off_a: assert property (busIn.byteLane1SelN &&
    $past(busIn.byteLane1SelN) && $past(busIn.byteLane1SelN, 2)
    |-> dataOe[15:8] == 8'h00) else $error("upper lane driven");
  // main scenarios reached
  cover property ($fell(busIn.readStrobeN) && !localDecodeHitN);
  cover property ($rose(asyncReadyOut));
  cover property (wrReq.valid);
endmodule

//--- bench/tb_top.sv
// testbench for the host port: lane table, refusals, stalled core
// assumes: unused upper-word pins are tied off outside this block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ihp_pkg::*;
  logic clk = 0, rst = 1, slow = 0, rdAck, rdy, hitN, rdReq;
  ihp_bus_in_t b = '1; // upper-word pins tied off by system
  ihp_wr_t wr, wrLast;
  logic [15:0] din = 0, dOut, dOe, rdData;
  logic [2:0] idx;
  logic [2:0] rows [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  int num_errors = 0, checked = 0, rdSeen = 0, wrSeen = 0;
  always #5 clk = ~clk;
  ihp_host_port dut (.clk, .rst, .busIn(b), .dataIn(din), .dataOut(dOut),
    .dataOe(dOe), .asyncReadyOut(rdy), .localDecodeHitN(hitN),
    .wrReq(wr), .rdReq, .rdIndex(idx), .rdAck, .rdData);
  ihp_core_model core (.clk, .rst, .slow, .rdReq, .rdIndex(idx), .rdAck,
    .rdData);
  // count requests leaving the port
  always @(posedge clk) begin
    if (rdReq === 1'b1) rdSeen++;
    if (wr.valid === 1'b1) begin wrSeen++; wrLast = wr; end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // one host access: set up, strobe, wait for ready, release
  task acc(input logic w, l1, l0, q, input logic [14:0] a,
           input logic [15:0] d);
    logic [15:0] m;
    logic h;
    int r0, w0, n;
    m = {{8{!l1}}, {8{!l0}}};
    h = a[14:3] == BASE_DECODE && !q;
    r0 = rdSeen; w0 = wrSeen; n = 0;
    @(posedge clk);
    b.addr <= a; b.ioQualifierN <= q; din <= d;
    b.byteLane1SelN <= l1; b.byteLane0SelN <= l0;
    @(posedge clk);
    if (w) b.writeStrobeN <= 0; else b.readStrobeN <= 0;
    repeat (2) @(posedge clk);
    while (rdy !== 1'b1 && n < 10) begin @(posedge clk); n++; end
    repeat (2) @(posedge clk);
    #1 chk(16'(rdy), 16'h1, "ready not back");
    if (!w) chk(dOe, h ? m : 16'h0, "lane enables");
    chk(16'(hitN), 16'(!h), "decode output");
    chk(16'(idx), 16'(a[2:0]), "read index");
    if (!w && h && !slow) chk(dOut & m, {5'h0, a[2:0], 5'h0, a[2:0]} & m,
      "read data");
    @(posedge clk);
    b.readStrobeN <= 1; b.writeStrobeN <= 1;
    repeat (3) @(posedge clk);
    #1 chk(dOe, 16'h0, "lanes left driven");
    chk(16'(rdSeen - r0), 16'(!w && h), "read requests");
    chk(16'(wrSeen - w0), 16'(w && h), "write requests");
    if (w && h) chk(wrLast.data, d & m, "write data");
    if (w && h) chk(16'(wrLast.index), 16'(a[2:0]), "write index");
    if (w && h) chk(16'(wrLast.lanes), 16'({!l1, !l0}), "lanes");
    $display("access done w=%0b q=%0b a=%h", w, q, a);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1 chk(16'(rdy), 16'h1, "ready after reset");
    chk(dOe | dOut, 16'h0, "outputs after reset");
    // lane table for reads and writes
    foreach (rows[i]) acc(rows[i][2], rows[i][1], rows[i][0], 0,
      {BASE_DECODE, 3'(i)}, 16'ha5c3 + 16'(i));
    acc(0, 0, 0, 1, {BASE_DECODE, 3'h3}, 16'h0);
    acc(1, 0, 0, 1, {BASE_DECODE, 3'h3}, 16'hffff);
    acc(0, 0, 0, 0, {12'h031, 3'h2}, 16'h0);
    slow <= 1;
    acc(0, 0, 1, 0, {BASE_DECODE, 3'h7}, 16'h0);
    slow <= 0;
    finish_test;
  end
  initial begin
    #100us;
    num_errors++;
    finish_test;
  end
endmodule
bind ihp_host_port ihp_sva chk_i (.*);

//--- hdl/ihp_host_port.sv
// 16-bit isa-style slave host port with ready stretching
// assumes: strobes sampled on clk; register core gives read data on rdAck
module ihp_host_port (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire ihp_pkg::ihp_bus_in_t busIn,
  input  wire logic [15:0]          dataIn,
  output logic [15:0]               dataOut,
  output logic [15:0]               dataOe,
  output logic                      asyncReadyOut,
  output logic                      localDecodeHitN,
  output ihp_pkg::ihp_wr_t          wrReq,
  output logic                      rdReq,
  output logic [2:0]                rdIndex,
  input  wire logic                 rdAck,
  input  wire logic [15:0]          rdData
);
  import ihp_pkg::*;

  // address match for this device's window
  function automatic logic decodeHit(input logic [ADDR_W:1] a,
                                     input logic qualN);
    decodeHit = (a[ADDR_W:4] == BASE_DECODE) && !qualN;
  endfunction

  ihp_state_t        state_reg, state_next;
  logic              rdPrev_reg, rdPrev_next;
  logic              wrPrev_reg, wrPrev_next;
  logic              ready_reg, ready_next;
  logic [15:0]       word_reg, word_next;
  logic [15:0]       wrData_reg, wrData_next;
  logic [1:0]        wrLanes_reg, wrLanes_next;
  logic [REG_AW-1:0] wrIdx_reg, wrIdx_next;
  ihp_wr_t           wr_reg, wr_next;
  logic [3:0]        wait_reg, wait_next;
  logic              rdReq_reg, rdReq_next;

  logic       hit;
  logic [1:0] laneSel;
  logic       rdFall, wrFall, wrRise;

  // lane select decode and strobe edges
  assign hit     = decodeHit(busIn.addr, busIn.ioQualifierN);
  assign laneSel = {~busIn.byteLane1SelN, ~busIn.byteLane0SelN};
  assign rdFall  = rdPrev_reg & ~busIn.readStrobeN;
  assign wrFall  = wrPrev_reg & ~busIn.writeStrobeN;
  assign wrRise  = ~wrPrev_reg & busIn.writeStrobeN;

  // access sequencing and ready control
  always_comb begin
    state_next   = state_reg;
    rdPrev_next  = busIn.readStrobeN;
    wrPrev_next  = busIn.writeStrobeN;
    ready_next   = ready_reg;
    word_next    = word_reg;
    wrData_next  = wrData_reg;
    wrLanes_next = wrLanes_reg;
    wrIdx_next   = wrIdx_reg;
    wr_next      = '0;
    wait_next    = wait_reg;
    rdReq_next   = 1'b0;
    unique case (state_reg)
      IDLE: begin
        if (rdFall && hit) begin
          ready_next = 1'b0;     // read must wait for the core
          rdReq_next = 1'b1;
          wait_next  = RD_LAT;
          state_next = RD_WAIT;
        end else if (wrFall && hit) begin
          ready_next   = 1'b1;   // writes never stall
          wrIdx_next   = busIn.addr[REG_AW:1];
          wrLanes_next = laneSel;
          state_next   = WR_HOLD;
        end
      end
      RD_WAIT: begin
        if (wait_reg != 4'h0) begin
          wait_next = wait_reg - 4'h1;
        end
        if (rdAck) begin
          word_next = rdData;
        end
        if (rdAck || (wait_reg == 4'h0)) begin
          ready_next = 1'b1;
          state_next = RD_HOLD;
        end
        if (busIn.readStrobeN) begin
          ready_next = 1'b1;
          state_next = IDLE;
        end
      end
      RD_HOLD: begin
        if (busIn.readStrobeN) begin
          state_next = IDLE;
        end
      end
      WR_HOLD: begin
        wrData_next = dataIn;           // track bus until trailing edge
        if (wrRise) begin
          wr_next.valid = 1'b1;
          wr_next.index = wrIdx_reg;
          wr_next.lanes = wrLanes_reg;
          for (int i = 0; i < 2; i++) begin
            wr_next.data[i*8 +: 8] =
              wrLanes_reg[i] ? wrData_reg[i*8 +: 8] : 8'h00;
          end
          state_next = IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg   <= IDLE;
      rdPrev_reg  <= 1'b1;
      wrPrev_reg  <= 1'b1;
      ready_reg   <= 1'b1;
      word_reg    <= 16'h0000;
      wrData_reg  <= 16'h0000;
      wrLanes_reg <= 2'b00;
      wrIdx_reg   <= '0;
      wr_reg      <= '0;
      wait_reg    <= 4'h0;
      rdReq_reg   <= 1'b0;
    end else begin
      state_reg   <= state_next;
      rdPrev_reg  <= rdPrev_next;
      wrPrev_reg  <= wrPrev_next;
      ready_reg   <= ready_next;
      word_reg    <= word_next;
      wrData_reg  <= wrData_next;
      wrLanes_reg <= wrLanes_next;
      wrIdx_reg   <= wrIdx_next;
      wr_reg      <= wr_next;
      wait_reg    <= wait_next;
      rdReq_reg   <= rdReq_next;
    end
  end

  // ready drops combinationally on a stalling read edge
  assign asyncReadyOut   = ready_reg & ~((state_reg == IDLE) & rdFall & hit);
  assign localDecodeHitN = ~hit;
  assign wrReq           = wr_reg;
  assign rdReq           = rdReq_reg;
  assign rdIndex         = busIn.addr[REG_AW:1];

  ihp_lane_drive lanes (
    .clk        (clk),
    .rst        (rst),
    .readActive (state_reg == RD_HOLD && !busIn.readStrobeN && hit),
    .laneSel    (laneSel),
    .readWord   (word_reg),
    .dataOut    (dataOut),
    .dataOe     (dataOe)
  );
endmodule

//--- hdl/ihp_lane_drive.sv
// data-bus lane driver: per-lane output enable during reads
// assumes: read data already registered in the caller
module ihp_lane_drive (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               readActive,
  input  wire logic [1:0]         laneSel,
  input  wire logic [15:0]        readWord,
  output logic [15:0]             dataOut,
  output logic [15:0]             dataOe
);
  import ihp_pkg::*;

  logic [15:0] dataOut_reg, dataOut_next;
  logic [15:0] dataOe_reg,  dataOe_next;

  // unselected lanes stay undriven on reads
  always_comb begin
    dataOut_next = readWord;
    for (int i = 0; i < 2; i++) begin
      dataOe_next[i*8 +: 8] = {8{readActive & laneSel[i]}};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dataOut_reg <= 16'h0000;
      dataOe_reg  <= 16'h0000;
    end else begin
      dataOut_reg <= dataOut_next;
      dataOe_reg  <= dataOe_next;
    end
  end

  assign dataOut = dataOut_reg;
  assign dataOe  = dataOe_reg;
endmodule

//--- hdl/ihp_pkg.sv
// package for the 16-bit isa-style host port: widths, decode, timing
// assumes: single 100 MHz clock, synchronous active-high reset
package ihp_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 15;  // address bits 15..1
  localparam int REG_AW = 3;   // word index inside the 16-byte window

  // address bits 15..4 that select this device
  localparam logic [11:0] BASE_DECODE = 12'h030;

  // internal side wait count before a read word is ready (cycles)
  localparam int RD_LAT_NS  = 30;
  localparam int CLK_NS     = 10;
  localparam int RD_LAT_CYC = (RD_LAT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] RD_LAT = 4'(RD_LAT_CYC);

  // pin bundle from the host
  typedef struct packed {
    logic [ADDR_W:1] addr;
    logic            ioQualifierN;
    logic            readStrobeN;
    logic            writeStrobeN;
    logic            byteLane0SelN;
    logic            byteLane1SelN;
  } ihp_bus_in_t;

  // write towards the register core
  typedef struct packed {
    logic              valid;
    logic [REG_AW-1:0] index;
    logic [1:0]        lanes;
    logic [DATA_W-1:0] data;
  } ihp_wr_t;

  typedef enum {
    IDLE,
    RD_WAIT,
    RD_HOLD,
    WR_HOLD
  } ihp_state_t;

endpackage
